// File: epb_host.sv
// Host controller driving a parallel byte-alterable memory module.
`timescale 1ns/100ps
`default_nettype none
module epb_host
    import epb_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic                reset_i,
    input  wire logic                req_valid_i,
    output logic                     req_ready_o,
    input  wire logic                req_write_i,
    input  wire logic                req_last_i,
    input  wire logic [ADDR_W-1:0]   req_addr_i,
    input  wire logic [DATA_W-1:0]   req_data_i,
    output logic                     rsp_valid_o,
    output logic [DATA_W-1:0]        rsp_data_o,
    output logic                     page_err_o,
    output logic [ADDR_W-1:0]        location_select_lines_o,
    input  wire logic [DATA_W-1:0]   byte_lines_i,
    output logic [DATA_W-1:0]        byte_lines_o,
    output logic                     byte_lines_oe_o,
    output logic                     sel_n_o,
    output logic                     out_n_o,
    output logic                     wr_n_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        EPH_IDLE = 4'b0001,
        EPH_XFER = 4'b0010,
        EPH_POLL = 4'b0100,
        EPH_WAIT = 4'b1000
    } eph_state_e;

    typedef struct packed {
        eph_state_e              st;
        logic                    rd;
        logic                    poll;
        logic                    last;
        logic                    in_page;
        logic [7:0]              count;
        logic [WIN_W-1:0]        win;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       data;
        logic [DATA_W-1:0]       rdata;
        logic [DATA_W-1:0]       sync1;
        logic [DATA_W-1:0]       sync2;
        logic [1:0]              strobe_d;
        logic [DATA_W-1:0]       samp;
        logic                    rvalid;
        logic                    perr;
    } eph_s;

    eph_s h_reg;
    eph_s h_next;

    epb_pin_if pin_bus ();

    epb_strobe_seq u_seq (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pins       (pin_bus.seq)
    );

    function automatic logic same_page(input logic [ADDR_W-1:0] a,
                                       input logic [ADDR_W-1:0] b);
        same_page = a[ADDR_W-1:PAGE_LO] == b[ADDR_W-1:PAGE_LO];
    endfunction

    logic accept;
    logic page_ok;
    logic closing;

    // A new write may join the open page only at the same page address
    // and before the page is full; otherwise it waits for programming.
    assign page_ok = !h_reg.in_page
        || (req_write_i && same_page(req_addr_i, h_reg.addr)
            && h_reg.count < PAGE_BYTES[7:0]);
    // A page that is about to be polled takes nothing more: a request
    // taken in that cycle would start a pin cycle on the old address and data and be lost.
    assign closing = h_reg.in_page && (h_reg.win == '0 || h_reg.last);
    assign req_ready_o = h_reg.st == EPH_IDLE && page_ok && !closing;
    assign accept = req_valid_i && req_ready_o;
    assign pin_bus.start = (h_reg.st == EPH_IDLE && accept)
        || (h_reg.st == EPH_POLL && !pin_bus.busy);
    assign pin_bus.is_read = h_reg.st == EPH_POLL || !req_write_i;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        h_next = h_reg;
        h_next.rvalid = 1'b0;
        // Byte lines are asynchronous; two flops before any use.
        h_next.sync1 = byte_lines_i;
        h_next.sync2 = h_reg.sync1;
        // Keep the last byte that entered the synchroniser while the
        // output strobe was low; released lines carry no valid data.
        h_next.strobe_d = {h_reg.strobe_d[0], !pin_bus.out_n};
        if (h_reg.strobe_d[1]) begin
            h_next.samp = h_reg.sync2;
        end
        if (h_reg.in_page && h_reg.win != '0) begin
            h_next.win = h_reg.win - 1'b1;
        end
        case (h_reg.st)
            EPH_IDLE: begin
                if (closing) begin
                    // Window ended or page marked last: nothing more loads, go poll.
                    h_next.st = EPH_POLL;
                    h_next.poll = 1'b1;
                end else if (accept) begin
                    h_next.st = EPH_XFER;
                    h_next.rd = !req_write_i;
                    h_next.addr = req_addr_i;
                    h_next.data = req_data_i;
                    h_next.last = req_last_i;
                    if (req_write_i) begin
                        h_next.in_page = 1'b1;
                        h_next.count = h_reg.count + ONE8;
                        h_next.win = LOAD_WIN_CYC[WIN_W-1:0];
                    end
                end else if (req_valid_i && req_write_i && !page_ok) begin
                    // A read is only held off while a page is open; just a
                    // write that breaks the page closes it early.
                    h_next.perr = 1'b1;
                    h_next.last = 1'b1;
                end
            end
            EPH_XFER: begin
                if (pin_bus.done) begin
                    h_next.st = EPH_WAIT;
                end
            end
            EPH_POLL: begin
                if (pin_bus.done) begin
                    h_next.st = EPH_WAIT;
                end
            end
            EPH_WAIT: begin
                // The byte held in samp was taken during the strobe.
                h_next.st = EPH_IDLE;
                if (h_reg.poll) begin
                    // Bit 6 stops toggling and bit 7 reads true at the end.
                    if (h_reg.samp[TOGGLE_BIT] == h_reg.rdata[TOGGLE_BIT]
                        && h_reg.samp[POLL_BIT] == h_reg.data[POLL_BIT]) begin
                        h_next.poll = 1'b0;
                        h_next.in_page = 1'b0;
                        h_next.last = 1'b0;
                        h_next.perr = 1'b0;
                        h_next.count = 8'h00;
                    end else begin
                        h_next.st = EPH_POLL;
                    end
                    h_next.rdata = h_reg.samp;
                end else if (h_reg.rd) begin
                    h_next.rdata = h_reg.samp;
                    h_next.rvalid = 1'b1;
                end
            end
            default: begin
                h_next.st = EPH_IDLE;
            end
        endcase
        if (reset_i) begin
            h_next = '0;
            h_next.st = EPH_IDLE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        h_reg <= h_next;
    end

    // ------------------------------------------------------------
    // Pins and answers
    // ------------------------------------------------------------
    assign location_select_lines_o = h_reg.addr;
    assign byte_lines_o            = h_reg.data;
    assign byte_lines_oe_o         = pin_bus.drive;
    assign sel_n_o                 = pin_bus.sel_n;
    assign out_n_o                 = pin_bus.out_n;
    assign wr_n_o                  = pin_bus.wr_n;
    assign rsp_valid_o             = h_reg.rvalid;
    assign rsp_data_o              = h_reg.rdata;
    assign page_err_o              = h_reg.perr;

    sequence s_wr_start;
        req_valid_i && req_ready_o && req_write_i;
    endsequence
    sequence s_wr_strobe;
        ##[1:8] !wr_n_o;
    endsequence

    page_load_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_wr_start |-> s_wr_strobe)
        else $error("Accepted write gave no strobe.");
    same_page_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (accept && req_write_i && h_reg.in_page)
        |-> same_page(req_addr_i, h_reg.addr))
        else $error("Page load crossed a page.");
    page_cap_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        h_reg.count <= PAGE_BYTES[7:0])
        else $error("Page holds over 128 bytes.");
    no_write_poll_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        h_reg.poll |-> !req_ready_o)
        else $error("Write taken while programming.");
    data_oe_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        byte_lines_oe_o |-> !sel_n_o && out_n_o)
        else $error("Byte lines driven in a read.");
    win_close_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (h_reg.st == EPH_IDLE && h_reg.in_page && h_reg.win == '0)
        |=> h_reg.st == EPH_POLL)
        else $error("Window end did not start polling.");
endmodule
`default_nettype wire

// File: epb_mem_model.sv
// Behavioural model of the parallel byte-alterable memory module.
`timescale 1ns/100ps
`default_nettype none
module epb_mem_model
    import epb_pkg::*;
#(
    parameter int WIN_NS  = LOAD_WIN_NS,
    // Shortened from the typical 5 ms so that a run stays brief.
    parameter int PROG_NS = 20000
)(
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              sel_n_i,
    input  wire logic              out_n_i,
    input  wire logic              wr_n_i,
    output logic [DATA_W-1:0]      data_o,
    output logic                   drive_o,
    output var int                 err_o = 0
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] page_q [int];
    logic [ADDR_W-1:0] wa = '0;
    logic [ADDR_W-1:0] last_a = '0;
    logic [DATA_W-1:0] last_d = '0;
    logic [DATA_W-1:0] rd = '0;
    logic              loading = 1'b0;
    logic              prog = 1'b0;
    logic              tog = 1'b1;
    time               t_fall = 0;
    // ------------------------------------------------------------
    // Strobe decoding
    // ------------------------------------------------------------
    // Released lines show the inverse of the last value, never a hold.
    assign drive_o = !sel_n_i && !out_n_i;
    assign data_o = drive_o ? rd : ~rd;
    always @(negedge sel_n_i or negedge wr_n_i) begin
        if (!sel_n_i && !wr_n_i) begin
            if (!out_n_i || prog) err_o++;
            if (loading && wa[ADDR_W-1:PAGE_LO] != addr_i[ADDR_W-1:PAGE_LO])
                err_o++;
            wa = addr_i;
            t_fall = $time;
        end
    end
    always @(posedge sel_n_i or posedge wr_n_i) begin
        if ((sel_n_i ^ wr_n_i) && out_n_i) begin
            page_q[int'(wa)] = data_i;
            last_a = wa;
            last_d = data_i;
            loading = 1'b1;
        end
    end
    always @(negedge out_n_i or negedge sel_n_i) begin
        if (!out_n_i && !sel_n_i) begin
            if (!wr_n_i) err_o++;
            rd = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 8'hFF;
            // The model is never write-protected, so status runs on every read of the last written address while loading or programming.
            if ((loading || prog) && addr_i == last_a) begin
                rd[POLL_BIT] = ~last_d[POLL_BIT];
                rd[TOGGLE_BIT] = tog;
                tog = ~tog;
            end
        end
    end
    always begin
        wait (loading);
        while ($time < t_fall + WIN_NS) #(t_fall + WIN_NS - $time);
        prog = 1'b1;
        loading = 1'b0;
        #(PROG_NS);
        foreach (page_q[k]) mem[k] = page_q[k];
        page_q.delete();
        prog = 1'b0;
    end
endmodule
`default_nettype wire

// File: epb_pin_if.sv
// Interface carrying the strobe sequencer's pin and request signals.
`timescale 1ns/100ps
`default_nettype none
interface epb_pin_if;
    import epb_pkg::*;
    logic              start;
    logic              is_read;
    logic              busy;
    logic              done;
    logic              sel_n;
    logic              out_n;
    logic              wr_n;
    logic              drive;
    modport seq (input start, input is_read,
                 output busy, output done,
                 output sel_n, output out_n, output wr_n, output drive);
    modport ctl (output start, output is_read,
                 input busy, input done,
                 input sel_n, input out_n, input wr_n, input drive);
endinterface
`default_nettype wire

// File: epb_pkg.sv
// Package of constants and types for the parallel memory bus host.
package epb_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam int PAGE_LO = 7;
    localparam int PAGE_BYTES = 128;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int CLK_NS = 10;
    // Strobe phase lengths in cycles; 30 cycles covers a 300 ns access.
    localparam logic [7:0] SETUP_CYC = 8'h02;
    localparam logic [7:0] STROBE_CYC = 8'h1E;
    localparam logic [7:0] HOLD_CYC = 8'h02;
    localparam int LOAD_WIN_NS = 100000;
    // Host keeps a margin under the load window: rounded down.
    localparam int LOAD_WIN_CYC = LOAD_WIN_NS / CLK_NS;
    localparam int WIN_W = 14;
    localparam logic [7:0] ONE8 = 8'h01;

    typedef enum logic [5:0] {
        EPB_IDLE   = 6'b00_0001,
        EPB_SETUP  = 6'b00_0010,
        EPB_STROBE = 6'b00_0100,
        EPB_HOLD   = 6'b00_1000,
        EPB_POLL   = 6'b01_0000,
        EPB_DONE   = 6'b10_0000
    } epb_state_e;
endpackage

// File: epb_strobe_seq.sv
// Strobe sequencer that times one read or write cycle on the pins.
`timescale 1ns/100ps
`default_nettype none
module epb_strobe_seq
    import epb_pkg::*;
(
    input  wire logic  core_clk_i,
    input  wire logic  reset_i,
    epb_pin_if.seq     pins
);
    typedef struct packed {
        epb_state_e st;
        logic [7:0] cnt;
        logic       rd;
    } epb_seq_s;

    epb_seq_s s_reg;
    epb_seq_s s_next;

    always_comb begin
        s_next = s_reg;
        case (s_reg.st)
            EPB_IDLE: begin
                if (pins.start) begin
                    s_next.st = EPB_SETUP;
                    s_next.rd = pins.is_read;
                    s_next.cnt = SETUP_CYC;
                end
            end
            EPB_SETUP, EPB_STROBE, EPB_HOLD: begin
                s_next.cnt = s_reg.cnt - ONE8;
                if (s_reg.cnt == ONE8) begin
                    if (s_reg.st == EPB_SETUP) begin
                        s_next.st = EPB_STROBE;
                        s_next.cnt = STROBE_CYC;
                    end else if (s_reg.st == EPB_STROBE) begin
                        s_next.st = EPB_HOLD;
                        s_next.cnt = HOLD_CYC;
                    end else begin
                        s_next.st = EPB_DONE;
                    end
                end
            end
            default: begin
                s_next.st = EPB_IDLE;
            end
        endcase
        if (reset_i) begin
            s_next = '{st: EPB_IDLE, cnt: 8'h00, rd: 1'b0};
        end
    end

    always_ff @(posedge core_clk_i) begin
        s_reg <= s_next;
    end

    // Select falls in setup and stays low through hold; only the strobe
    // pulses, so the write strobe edges control the device's latching.
    assign pins.sel_n = !(s_reg.st inside {EPB_SETUP, EPB_STROBE, EPB_HOLD});
    assign pins.out_n = !(s_reg.rd && s_reg.st == EPB_STROBE);
    assign pins.wr_n  = !(!s_reg.rd && s_reg.st == EPB_STROBE);
    // Data driven from setup to hold so it is stable at the rising edge.
    assign pins.drive = !s_reg.rd && !pins.sel_n;
    assign pins.busy  = s_reg.st != EPB_IDLE;
    assign pins.done  = s_reg.st == EPB_DONE;

    wr_excl_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !(pins.out_n == 1'b0 && pins.wr_n == 1'b0))
        else $error("Output and write strobes low together.");
    rd_sel_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !pins.out_n |-> !pins.sel_n)
        else $error("Output strobe low without select.");
endmodule
`default_nettype wire

// File: test_epb_host.sv
// Self-checking testbench of the parallel memory bus host.
`timescale 1ns/100ps
`default_nettype none
module test_epb_host;
    import epb_pkg::*;
    logic              core_clk = 1'b0;
    logic              reset = 1'b1;
    logic              req_valid = 1'b0;
    logic              req_write = 1'b0;
    logic              req_last = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_data = '0;
    logic              req_ready_o, rsp_valid_o, page_err_o, oe;
    logic              sel_n, out_n, wr_n, dev_drive;
    logic [DATA_W-1:0] rsp_data_o, host_d, dev_d, byte_bus, v;
    logic [ADDR_W-1:0] pins_a;
    int                fail_count = 0;
    int                num_checks = 0;
    int                n, dev_err;
    // ------------------------------------------------------------
    // Bench structure
    // ------------------------------------------------------------
    always #5 core_clk = ~core_clk;
    assign byte_bus = oe ? host_d : dev_d;
    epb_host dut_u (.core_clk_i(core_clk), .reset_i(reset),
        .req_valid_i(req_valid), .req_ready_o(req_ready_o),
        .req_write_i(req_write), .req_last_i(req_last),
        .req_addr_i(req_addr), .req_data_i(req_data),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .page_err_o(page_err_o), .location_select_lines_o(pins_a),
        .byte_lines_i(byte_bus), .byte_lines_o(host_d),
        .byte_lines_oe_o(oe), .sel_n_o(sel_n), .out_n_o(out_n),
        .wr_n_o(wr_n));
    epb_mem_model mem_u (.addr_i(pins_a), .data_i(byte_bus),
        .sel_n_i(sel_n), .out_n_i(out_n), .wr_n_i(wr_n),
        .data_o(dev_d), .drive_o(dev_drive), .err_o(dev_err));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Called at a falling edge; returns at the falling edge after the take.
    // One edge passes first so valid never falls and rises in one step.
    task automatic send(input logic w, input logic l,
                        input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req_write = w;
        req_last = l;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        #1;
        while (req_ready_o !== 1'b1) begin
            @(negedge core_clk);
            #1;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d,
                      output int c);
        send(1'b0, 1'b0, a, 8'h00);
        c = 0;
        while (rsp_valid_o !== 1'b1 && c < 100) begin
            @(negedge core_clk);
            c++;
        end
        chk(rsp_valid_o, 1'b1);
        d = rsp_data_o;
    endtask
    task automatic wait_idle;
        #1;
        while (req_ready_o !== 1'b1) begin
            @(negedge core_clk);
            #1;
        end
        @(negedge core_clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_byte;
        // No last flag: the page closes only when the load window ends.
        send(1'b1, 1'b0, 18'h2_0105, 8'h5A);
        wait_idle();
        rd(18'h2_0105, v, n);
        chk(v, 8'h5A);
        chk(n, SETUP_CYC + STROBE_CYC + HOLD_CYC + 2);
    endtask
    task automatic t_page;
        for (int i = 0; i < PAGE_BYTES; i++)
            send(1'b1, i == PAGE_BYTES - 1, 18'h1_2380 + i, i ^ 8'h3C);
        wait_idle();
        for (int i = 0; i < PAGE_BYTES; i++) begin
            rd(18'h1_2380 + i, v, n);
            chk(v, i ^ 8'h3C);
        end
    endtask
    task automatic t_page_err;
        send(1'b1, 1'b0, 18'h0_0100, 8'h11);
        @(negedge core_clk);
        req_addr = 18'h0_0200;
        req_valid = 1'b1;
        n = 0;
        while (page_err_o !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        chk(page_err_o, 1'b1);
        req_valid = 1'b0;
        wait_idle();
        chk(page_err_o, 1'b0);
        rd(18'h0_0100, v, n);
        chk(v, 8'h11);
        rd(18'h0_0200, v, n);
        chk(v, 8'hFF);
    endtask
    always @(negedge core_clk) if (dev_drive) chk(oe, 1'b0);
    initial begin
        // Three page closes of about 12,000 cycles each plus the traffic.
        #800_000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        chk({sel_n, out_n, wr_n, oe}, 4'b1110);
        t_byte();
        t_page();
        t_page_err();
        chk(dev_err, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
